//--- include/amc_pkg.sv
// package for the converter main control register block
// assumes a single 100 mhz clock domain and an axi4-lite register bus
package amc_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] AMC_OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] AMC_OFF_STATUS = 8'h04;
  localparam logic [7:0] AMC_OFF_EVT_STATUS = 8'h08;
  localparam logic [7:0] AMC_OFF_EVT_CLEAR = 8'h0c;
  localparam logic [7:0] AMC_OFF_EVT_ENABLE = 8'h10;
  localparam logic [7:0] AMC_OFF_SPECIAL = 8'h14;

  // ****************************************************************
  // main control field positions
  // ****************************************************************
  localparam int AMC_BIT_ENABLE = 15;
  localparam int AMC_BIT_SOFT_RESET = 14;
  localparam int AMC_BIT_FREEZE = 13;
  localparam int AMC_BIT_WAIT = 12;
  localparam int AMC_BIT_ACC_HI = 11;
  localparam int AMC_BIT_ACC_LO = 10;
  localparam int AMC_BIT_STORE = 9;
  localparam int AMC_BIT_FLOW_MODE = 8;
  localparam logic [15:0] AMC_MAIN_RESET = 16'h0000;

  // ****************************************************************
  // event bits in status, clear and enable registers
  // ****************************************************************
  localparam int AMC_EVT_SRST_DONE = 0;
  localparam int AMC_EVT_DIS_DONE = 1;
  localparam int AMC_EVT_REC_DONE = 2;
  localparam int AMC_EVT_SEVERE = 3;
  localparam int AMC_NUM_EVT = 4;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int AMC_CLK_MHZ = 100;
  localparam int AMC_T_DISABLE_NS = 500;
  localparam int AMC_ENABLE_RECOVERY_TIME_NS = 2000;
  localparam int AMC_T_SRST_NS = 40;
  localparam int AMC_DIS_CYC = (AMC_T_DISABLE_NS * AMC_CLK_MHZ) / 1000;
  localparam int AMC_REC_CYC = (AMC_ENABLE_RECOVERY_TIME_NS * AMC_CLK_MHZ + 999) / 1000;
  localparam int AMC_SRST_CYC = (AMC_T_SRST_NS * AMC_CLK_MHZ + 999) / 1000;
  localparam int AMC_CNT_W = 12;

  // converter sequencing states, gray along the usual path
  typedef enum logic [1:0] {
    AMC_ST_OFF = 2'b00,
    AMC_ST_RECOVER = 2'b01,
    AMC_ST_ON = 2'b11,
    AMC_ST_DISABLING = 2'b10
  } amc_state_t;

  // flow register access paths
  typedef enum logic [1:0] {
    AMC_ACC_NONE = 2'b00,
    AMC_ACC_INTERNAL = 2'b01,
    AMC_ACC_BUS = 2'b10,
    AMC_ACC_BOTH = 2'b11
  } amc_acc_t;

endpackage : amc_pkg

//--- include/amc_seq_if.sv
// interface between the control register and the sequencing timer
// assumes both ends on clk_sys
interface amc_seq_if;
  logic enable_req;
  logic soft_reset_req;
  logic soft_reset_done;
  logic conv_enabled;
  logic abort;
  logic recovery_done;
  logic disable_done;
  logic [1:0] state;

  modport ctrl (
    output enable_req,
    output soft_reset_req,
    input soft_reset_done,
    input conv_enabled,
    input abort,
    input recovery_done,
    input disable_done,
    input state
  );
  modport seq (
    input enable_req,
    input soft_reset_req,
    output soft_reset_done,
    output conv_enabled,
    output abort,
    output recovery_done,
    output disable_done,
    output state
  );
endinterface : amc_seq_if

//--- rtl/amc_seq.sv
// enable, disable, recovery and soft reset sequencing timer
// assumes clk_sys at 100 mhz and a synchronous active-low reset
module amc_seq
  import amc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // link to control register
  amc_seq_if.seq sq
);

  amc_state_t state_r;
  logic [AMC_CNT_W-1:0] cnt_r;
  logic [AMC_CNT_W-1:0] srst_cnt_r;
  logic srst_busy_r;

  // ****************************************************************
  // enable state machine
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= AMC_ST_OFF;
      cnt_r <= '0;
    end else if (clk_en) begin
      case (state_r)
        AMC_ST_OFF: begin
          if (sq.enable_req) begin
            state_r <= AMC_ST_RECOVER;
            cnt_r <= AMC_CNT_W'(AMC_REC_CYC - 1);
          end
        end
        AMC_ST_RECOVER: begin
          if (!sq.enable_req) begin
            state_r <= AMC_ST_DISABLING;
            cnt_r <= AMC_CNT_W'(AMC_DIS_CYC - 1);
          end else if (cnt_r == '0) begin
            state_r <= AMC_ST_ON;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        AMC_ST_ON: begin
          if (!sq.enable_req) begin
            state_r <= AMC_ST_DISABLING;
            cnt_r <= AMC_CNT_W'(AMC_DIS_CYC - 1);
          end
        end
        AMC_ST_DISABLING: begin
          // no re-enable until the abort has drained
          if (cnt_r == '0) begin
            state_r <= AMC_ST_OFF;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= AMC_ST_OFF;
        end
      endcase
    end
  end

  // ****************************************************************
  // soft reset timer
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      srst_busy_r <= 1'b0;
      srst_cnt_r <= '0;
    end else if (clk_en) begin
      if (srst_busy_r) begin
        if (srst_cnt_r == '0) begin
          srst_busy_r <= 1'b0;
        end else begin
          srst_cnt_r <= srst_cnt_r - 1'b1;
        end
      end else if (sq.soft_reset_req) begin
        srst_busy_r <= 1'b1;
        srst_cnt_r <= AMC_CNT_W'(AMC_SRST_CYC - 1);
      end
    end
  end

  // status toward the register
  assign sq.conv_enabled = (state_r == AMC_ST_ON);
  assign sq.abort = (state_r == AMC_ST_DISABLING);
  assign sq.recovery_done = (state_r == AMC_ST_RECOVER) && sq.enable_req
    && (cnt_r == '0) && clk_en;
  assign sq.disable_done = (state_r == AMC_ST_DISABLING) && (cnt_r == '0)
    && clk_en;
  assign sq.soft_reset_done = srst_busy_r && (srst_cnt_r == '0) && clk_en;
  assign sq.state = state_r;

endmodule : amc_seq

//--- rtl/amc_main_ctrl.sv
// converter main control register with axi4-lite slave and event irq
// assumes clk_sys at 100 mhz, synchronous active-low reset, and that
// freeze, wait and severe-error inputs come from clk_sys logic
//
// Functional notes
// - enable, soft reset, freeze and wait bits are writable at any time
// - flow mode, store and access bits locked while enabled unless unlocked
// - bit 15 enables converter analog parts and gates protected writes
// - clearing enable aborts running sequence and discards pending results
// - no re-enable until disable latency has elapsed; software waits too
// - bit 14 soft reset clears error flags and idles the state machine
// - soft reset clears command and result indices and list selects
// - severe error stops operation until a soft reset is issued
// - soft reset bit is not software-clearable; hardware clears it when done
// - bit 13 set stops conversion at next boundary during freeze
// - bit 12 set halts conversion at next boundary during wait
// - bits 11:10 choose paths reaching the flow control register
// - access field 00 none, 01 internal, 10 bus, 11 both
// - bit 8 selects restart mode at 0 or trigger mode at 1
// - bit 9 sets whether interrupted conversions store their results
//
// Design decision made here: the AXI4-Lite slave port.
module amc_main_ctrl
  import amc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system mode and error inputs
  input wire logic freeze_mode,
  input wire logic wait_mode,
  input wire logic severe_error,
  input wire logic conv_boundary,
  // converter controls
  output logic analog_enable,
  output logic conv_run,
  output logic conv_abort,
  output logic discard_results,
  output logic flow_mode_select,
  output logic abort_result_store,
  output amc_pkg::amc_acc_t flow_reg_access_select,
  output logic flow_access_internal,
  output logic flow_access_bus,
  output logic fsm_idle_force,
  output logic clear_error_flags,
  output logic clear_command_index,
  output logic clear_result_index,
  output logic clear_command_list_select,
  output logic clear_result_list_select,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [15:0] main_r;
  logic special_mode_write_unlock_r;
  logic [AMC_NUM_EVT-1:0] evt_stat_r;
  logic [AMC_NUM_EVT-1:0] evt_en_r;
  logic halted_r;
  logic halted_nxt;
  logic severe_stop_r;
  logic [7:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic wr_fire;
  logic [AMC_NUM_EVT-1:0] evt_set;
  logic [AMC_NUM_EVT-1:0] evt_clr;
  logic wr_main;
  logic prot_open;
  logic [31:0] rd_word;

  amc_seq_if sq_if ();

  // ****************************************************************
  // sequencing timer
  // ****************************************************************
  amc_seq u_seq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sq(sq_if.seq)
  );

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  // capture address and data in either order
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response, slverr on unmapped address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_r)
          AMC_OFF_MAIN_CTRL, AMC_OFF_EVT_CLEAR, AMC_OFF_EVT_ENABLE,
          AMC_OFF_SPECIAL, AMC_OFF_STATUS, AMC_OFF_EVT_STATUS: begin
            s_axi_bresp <= 2'b00;
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_main = wr_fire && (awaddr_r == AMC_OFF_MAIN_CTRL);
  // protected fields open while disabled or unlocked
  assign prot_open = !main_r[AMC_BIT_ENABLE]
    || special_mode_write_unlock_r;

  // ****************************************************************
  // main control register, always-writable bits
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_r[15:12] <= AMC_MAIN_RESET[15:12];
    end else if (clk_en) begin
      if (wr_main && wstrb_r[1]) begin
        main_r[AMC_BIT_ENABLE] <= wdata_r[AMC_BIT_ENABLE];
        main_r[AMC_BIT_FREEZE] <= wdata_r[AMC_BIT_FREEZE];
        main_r[AMC_BIT_WAIT] <= wdata_r[AMC_BIT_WAIT];
      end
      // set from a write wins; only hardware completion clears it
      if (wr_main && wstrb_r[1] && wdata_r[AMC_BIT_SOFT_RESET]) begin
        main_r[AMC_BIT_SOFT_RESET] <= 1'b1;
      end else if (sq_if.soft_reset_done) begin
        main_r[AMC_BIT_SOFT_RESET] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // main control register, protected bits
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_r[11:8] <= AMC_MAIN_RESET[11:8];
    end else if (clk_en) begin
      if (wr_main && wstrb_r[1] && prot_open) begin
        main_r[AMC_BIT_ACC_HI:AMC_BIT_ACC_LO] <=
          wdata_r[AMC_BIT_ACC_HI:AMC_BIT_ACC_LO];
        main_r[AMC_BIT_STORE] <= wdata_r[AMC_BIT_STORE];
        main_r[AMC_BIT_FLOW_MODE] <= wdata_r[AMC_BIT_FLOW_MODE];
      end
    end
  end

  // unimplemented low byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_r[7:0] <= AMC_MAIN_RESET[7:0];
    end else if (clk_en) begin
      main_r[7:0] <= 8'h00;
    end
  end

  // special-mode unlock register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      special_mode_write_unlock_r <= 1'b0;
    end else if (clk_en && wr_fire && awaddr_r == AMC_OFF_SPECIAL
      && wstrb_r[0]) begin
      special_mode_write_unlock_r <= wdata_r[0];
    end
  end

  // ****************************************************************
  // sequencing hooks
  // ****************************************************************
  assign sq_if.enable_req = main_r[AMC_BIT_ENABLE];
  assign sq_if.soft_reset_req = main_r[AMC_BIT_SOFT_RESET];

  // severe stop, lifted by soft reset; a coincident error wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      severe_stop_r <= 1'b0;
    end else if (clk_en) begin
      if (severe_error) begin
        severe_stop_r <= 1'b1;
      end else if (sq_if.soft_reset_done) begin
        severe_stop_r <= 1'b0;
      end
    end
  end

  // freeze and wait halt at a conversion boundary
  always_comb begin
    halted_nxt = halted_r;
    if ((freeze_mode && main_r[AMC_BIT_FREEZE])
      || (wait_mode && main_r[AMC_BIT_WAIT])) begin
      if (conv_boundary) begin
        halted_nxt = 1'b1;
      end
    end else begin
      halted_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      halted_r <= 1'b0;
    end else if (clk_en) begin
      halted_r <= halted_nxt;
    end
  end

  // ****************************************************************
  // converter control outputs
  // ****************************************************************
  assign analog_enable = main_r[AMC_BIT_ENABLE]
    || (sq_if.state != 2'b00);
  assign conv_run = sq_if.conv_enabled && !halted_r && !severe_stop_r
    && !main_r[AMC_BIT_SOFT_RESET];
  assign conv_abort = sq_if.abort;
  assign discard_results = sq_if.abort;
  assign flow_mode_select = main_r[AMC_BIT_FLOW_MODE];
  assign abort_result_store = main_r[AMC_BIT_STORE];
  assign flow_reg_access_select =
    amc_acc_t'(main_r[AMC_BIT_ACC_HI:AMC_BIT_ACC_LO]);
  assign flow_access_internal = main_r[AMC_BIT_ACC_LO];
  assign flow_access_bus = main_r[AMC_BIT_ACC_HI];
  assign fsm_idle_force = main_r[AMC_BIT_SOFT_RESET];
  assign clear_error_flags = sq_if.soft_reset_done;
  assign clear_command_index = sq_if.soft_reset_done;
  assign clear_result_index = sq_if.soft_reset_done;
  assign clear_command_list_select = sq_if.soft_reset_done;
  assign clear_result_list_select = sq_if.soft_reset_done;

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  always_comb begin
    evt_set = '0;
    evt_set[AMC_EVT_SRST_DONE] = sq_if.soft_reset_done;
    evt_set[AMC_EVT_DIS_DONE] = sq_if.disable_done;
    evt_set[AMC_EVT_REC_DONE] = sq_if.recovery_done;
    evt_set[AMC_EVT_SEVERE] = severe_error && clk_en;
  end

  assign evt_clr = (wr_fire && awaddr_r == AMC_OFF_EVT_CLEAR && wstrb_r[0])
    ? wdata_r[AMC_NUM_EVT-1:0] : '0;

  // sticky bits: a set in the clear cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < AMC_NUM_EVT; gi = gi + 1) begin : g_evt
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          evt_stat_r[gi] <= 1'b0;
        end else if (clk_en) begin
          if (evt_set[gi]) begin
            evt_stat_r[gi] <= 1'b1;
          end else if (evt_clr[gi]) begin
            evt_stat_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      evt_en_r <= '0;
    end else if (clk_en && wr_fire && awaddr_r == AMC_OFF_EVT_ENABLE
      && wstrb_r[0]) begin
      evt_en_r <= wdata_r[AMC_NUM_EVT-1:0];
    end
  end

  assign irq = |(evt_stat_r & evt_en_r);

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      AMC_OFF_MAIN_CTRL: rd_word[15:0] = main_r;
      AMC_OFF_STATUS: begin
        rd_word[1:0] = sq_if.state;
        rd_word[2] = severe_stop_r;
        rd_word[3] = halted_r;
        rd_word[4] = conv_run;
      end
      AMC_OFF_EVT_STATUS: rd_word[AMC_NUM_EVT-1:0] = evt_stat_r;
      AMC_OFF_EVT_ENABLE: rd_word[AMC_NUM_EVT-1:0] = evt_en_r;
      AMC_OFF_SPECIAL: rd_word[0] = special_mode_write_unlock_r;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data registered, slverr on unmapped address; the write-only clear register reads zero with okay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        case (s_axi_araddr)
          AMC_OFF_MAIN_CTRL, AMC_OFF_STATUS, AMC_OFF_EVT_STATUS,
          AMC_OFF_EVT_ENABLE, AMC_OFF_SPECIAL, AMC_OFF_EVT_CLEAR: begin
            s_axi_rresp <= 2'b00;
          end
          default: begin
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : amc_main_ctrl

//--- verif/amc_chk.sv
// checker for the converter main control register block
// assumes it is bound to amc_main_ctrl and sees only its ports
module amc_chk
  import amc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // converter controls
  input wire logic analog_enable,
  input wire logic conv_run,
  input wire logic conv_abort,
  input wire logic discard_results,
  input wire amc_pkg::amc_acc_t flow_reg_access_select,
  input wire logic flow_access_internal,
  input wire logic flow_access_bus,
  input wire logic fsm_idle_force,
  input wire logic clear_command_index,
  input wire logic clear_result_index,
  input wire logic clear_command_list_select,
  input wire logic clear_result_list_select
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  flow_int_a: assert property (
    flow_access_internal == flow_reg_access_select[0])
    else $error("internal flag wrong");
  flow_bus_a: assert property (
    flow_access_bus == flow_reg_access_select[1])
    else $error("bus flag wrong");
  rst_zero_a: assert property (
    $rose(rst_n) |-> !analog_enable && !fsm_idle_force &&
    flow_reg_access_select == AMC_ACC_NONE)
    else $error("nonzero after reset");
  run_en_a: assert property (
    conv_run |-> analog_enable)
    else $error("run while disabled");
  srst_run_a: assert property (
    fsm_idle_force |-> !conv_run)
    else $error("run in soft reset");
  srst_hold_a: assert property (
    $rose(fsm_idle_force) |-> fsm_idle_force [*4])
    else $error("soft reset too short");
  abort_pair_a: assert property (
    conv_abort == discard_results)
    else $error("abort and discard disagree");
  abort_on_a: assert property (
    conv_abort |-> analog_enable && !conv_run)
    else $error("bad outputs while disabling");
  clr_all_a: assert property (
    clear_command_index |-> clear_result_index &&
    clear_command_list_select && clear_result_list_select)
    else $error("clears split");
  clr_once_a: assert property (
    clear_command_index |=> !clear_command_index)
    else $error("clear pulse too long");
endmodule : amc_chk

bind amc_main_ctrl amc_chk amc_chk_i (
  .clk_sys,
  .rst_n,
  .analog_enable,
  .conv_run,
  .conv_abort,
  .discard_results,
  .flow_reg_access_select,
  .flow_access_internal,
  .flow_access_bus,
  .fsm_idle_force,
  .clear_command_index,
  .clear_result_index,
  .clear_command_list_select,
  .clear_result_list_select
);

//--- verif/testbench.sv
// self-checking bench for the converter main control register block
// assumes amc_pkg and amc_main_ctrl compiled first, 100 mhz clk_sys
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import amc_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic frz = 1'b0, wt = 1'b0, sev = 1'b0, bnd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv;
  logic an, run, abrt, disc, fms, ars, fia, fib, idle, irq;
  logic cef, cci, cri, ccl, crl;
  amc_acc_t acc;
  int err_count = 0, cmp_count = 0, cyc = 0, nclr = 0;

  amc_main_ctrl amc_main_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .freeze_mode(frz), .wait_mode(wt),
    .severe_error(sev), .conv_boundary(bnd), .analog_enable(an),
    .conv_run(run), .conv_abort(abrt), .discard_results(disc),
    .flow_mode_select(fms), .abort_result_store(ars),
    .flow_reg_access_select(acc), .flow_access_internal(fia),
    .flow_access_bus(fib), .fsm_idle_force(idle),
    .clear_error_flags(cef), .clear_command_index(cci),
    .clear_result_index(cri), .clear_command_list_select(ccl),
    .clear_result_list_select(crl), .irq(irq));

  // clock, clear counter, timeout
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (cci === 1'b1 && cef === 1'b1) nclr++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************************************
  // bus tasks and comparisons
  // ****************************************************************
  task ck(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : ck
  task ckb(input logic g, input logic e, input string m);
    ck({31'h0, g}, {31'h0, e}, m);
  endtask : ckb
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk_sys);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  // bounded state poll
  task wst(input logic [1:0] s);
    int n;
    n = 0;
    rd(AMC_OFF_STATUS);
    while (rv[1:0] !== s && n < 400) begin
      rd(AMC_OFF_STATUS);
      n++;
    end
    ck(rv[1:0], s, "state not reached");
  endtask : wst
  task summarize();
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset();
    rd(AMC_OFF_MAIN_CTRL);
    ck(rv, 32'h0, "ctrl not zero");
    ck({30'h0, acc}, 32'h0, "access not none");
    rd(8'h20);
    ck(rs, 2'b10, "unmapped read ok");
    wr(8'h20, 32'h1);
    ck(rs, 2'b10, "unmapped write ok");
  endtask : t_reset
  // all access codes while disabled
  task t_acc();
    logic [31:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (i << 10) | (i << 8);
      wr(AMC_OFF_MAIN_CTRL, e);
      rd(AMC_OFF_MAIN_CTRL);
      ck(rv, e, "protected write lost");
      ck({fib, fia}, i, "paths wrong");
      ck({ars, fms}, i, "store/mode wrong");
    end
  endtask : t_acc
  task t_lock();
    wr(AMC_OFF_MAIN_CTRL, 32'h8300);
    rd(AMC_OFF_STATUS);
    ck(rv[1:0], 2'b01, "no recovery");
    ckb(run, 1'b0, "running in recovery");
    wr(AMC_OFF_MAIN_CTRL, 32'hb000);
    rd(AMC_OFF_MAIN_CTRL);
    ck(rv, 32'hb300, "lock wrong");
    wr(AMC_OFF_SPECIAL, 32'h1);
    wr(AMC_OFF_MAIN_CTRL, 32'h8c00);
    rd(AMC_OFF_MAIN_CTRL);
    ck(rv, 32'h8c00, "unlock write lost");
    wr(AMC_OFF_SPECIAL, 32'h0);
  endtask : t_lock
  task t_enable();
    wr(AMC_OFF_EVT_ENABLE, 32'h4);
    wst(2'b11);
    ckb(run, 1'b1, "not running");
    rd(AMC_OFF_EVT_STATUS);
    ckb(rv[AMC_EVT_REC_DONE], 1'b1, "no recovery event");
    ckb(irq, 1'b1, "no irq");
    wr(AMC_OFF_EVT_CLEAR, 32'h4);
    ckb(irq, 1'b0, "irq stuck");
  endtask : t_enable
  // freeze halting, wait halting, and no halt in freeze with both halt bits clear
  task t_halt();
    for (int i = 0; i < 3; i++) begin
      wr(AMC_OFF_MAIN_CTRL, i == 0 ? 32'ha000 : 32'h9000);
      if (i == 2) wr(AMC_OFF_MAIN_CTRL, 32'h8000);
      frz <= (i != 1);
      wt <= (i == 1);
      @(posedge clk_sys);
      ckb(run, 1'b1, "early halt");
      bnd <= 1'b1;
      @(posedge clk_sys);
      bnd <= 1'b0;
      @(posedge clk_sys);
      ckb(run, i == 2, "halt wrong");
      frz <= 1'b0;
      wt <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ckb(run, 1'b1, "no resume");
    end
  endtask : t_halt
  task t_severe();
    int n;
    sev <= 1'b1;
    @(posedge clk_sys);
    sev <= 1'b0;
    @(posedge clk_sys);
    ckb(run, 1'b0, "severe ignored");
    n = nclr;
    wr(AMC_OFF_MAIN_CTRL, 32'hc000);
    repeat (10) @(posedge clk_sys);
    ck(nclr - n, 32'h1, "clear count");
    ckb(idle, 1'b0, "srst stuck");
    ckb(run, 1'b1, "no run after srst");
  endtask : t_severe
  task t_disable();
    wr(AMC_OFF_EVT_ENABLE, 32'h0);
    wr(AMC_OFF_MAIN_CTRL, 32'h0);
    @(posedge clk_sys);
    ckb(abrt, 1'b1, "no abort");
    ckb(an, 1'b1, "analog dropped early");
    wr(AMC_OFF_MAIN_CTRL, 32'h8000);
    rd(AMC_OFF_STATUS);
    ck(rv[1:0], 2'b10, "re-enabled early");
    wr(AMC_OFF_MAIN_CTRL, 32'h0);
    wst(2'b00);
    ckb(an, 1'b0, "analog still on");
    rd(AMC_OFF_EVT_STATUS);
    ckb(rv[AMC_EVT_DIS_DONE], 1'b1, "no disable event");
    ckb(irq, 1'b0, "masked irq");
  endtask : t_disable

  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_acc();
    t_lock();
    t_enable();
    t_halt();
    t_severe();
    t_disable();
    summarize();
  end
endmodule : testbench
